//--- erc_restart_ctrl.sv
// restart sequencer, time base, event buffer and apb word image
`timescale 1ns/1ps
`default_nettype none
`include "erc_map.svh"

module erc_restart_ctrl #(
    parameter int unsigned MS_CYCLES = `ERC_CLK_HZ * `ERC_RESOLVE_MS / 32'd1000
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        proc_in,
    input  wire logic        time_code,
    input  wire logic        power_fail,
    input  wire logic        battery_ok,
    input  wire logic [31:0] nv_rdata,
    output logic             nv_we,
    output logic [7:0]       nv_addr,
    output logic [31:0]      nv_wdata,
    output logic             irq
);
    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    erc_pkg::erc_regs_t r_ff;
    erc_pkg::erc_regs_t nxt_r;

    // ======================================================================
    // helpers
    // word slot of an address: {valid, out-side, index}
    function automatic logic [4:0] erc_slot(input logic [7:0] a);
        logic [4:0] s;
        s = 5'h00;
        if (a >= `ERC_IN_BASE && a < `ERC_IN_BASE + {3'h0, `ERC_IN_WORDS, 2'h0} && a[1:0] == 2'h0)
            s = {1'b1, 1'b0, a[4:2]};
        else if (a >= `ERC_OUT_BASE && a < `ERC_OUT_BASE + {3'h0, `ERC_OUT_WORDS, 2'h0} && a[1:0] == 2'h0)
            s = {1'b1, 1'b1, a[4:2]};
        return s;
    endfunction

    function automatic logic [31:0] erc_read(input erc_pkg::erc_regs_t s, input logic [7:0] a);
        logic [4:0]  k;
        logic [31:0] d;
        k = erc_slot(a);
        d = 32'h0000_0000;
        if (a == `ERC_IRQ_STAT)
            d = {28'h0, s.irq_stat};
        else if (a == `ERC_IRQ_MASK)
            d = {28'h0, s.irq_mask};
        else if (k[4] && !k[3]) begin
            case (k[2:0])
                3'h0:    d = {s.st, 19'h0, s.level, s.overrun, s.par_ok, s.warm, s.tvalid};
                3'h1:    d = (s.count != 4'h0) ? s.fifo[s.rd_ptr] : 32'h0000_0000;
                3'h2:    d = s.counter;
                3'h3:    d = {5'h0, s.sec, s.ms};
                3'h4:    d = s.date;
                3'h5:    d = {28'h0, s.count};
                default: d = {24'h0, s.param};
            endcase
        end else if (k[4]) begin
            case (k[2:0])
                3'h0:    d = {27'h0, s.ctrl};
                3'h1:    d = {24'h0, s.param};
                default: d = 32'h0000_0000;
            endcase
        end
        return d;
    endfunction

    // word of the saved image at a given slot
    function automatic logic [31:0] erc_nv_word(input erc_pkg::erc_regs_t s, input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            `ERC_NV_MARK_A:  d = `ERC_NV_MARK;
            `ERC_NV_PARAM_A: d = {23'h0, s.par_ok, s.param};
            `ERC_NV_CTRL_A:  d = {27'h0, s.ctrl};
            `ERC_NV_CNT_A:   d = s.counter;
            `ERC_NV_PTR_A:   d = {22'h0, s.rd_ptr, s.wr_ptr, s.count};
            default:         d = s.fifo[3'(a - `ERC_NV_EVT_A)];
        endcase
        return d;
    endfunction

    // full buffer keeps old entries and flags the loss
    function automatic erc_pkg::erc_regs_t erc_push(input erc_pkg::erc_regs_t s, input logic [31:0] w);
        erc_pkg::erc_regs_t t;
        t = s;
        if (s.count == `ERC_EVT_DEPTH) begin
            t.overrun = 1'b1;
        end else begin
            t.fifo[s.wr_ptr] = w;
            t.wr_ptr         = s.wr_ptr + 3'h1;
            t.count          = s.count + 4'h1;
        end
        return t;
    endfunction

    function automatic erc_pkg::erc_regs_t erc_wipe(input erc_pkg::erc_regs_t s, input logic ev, input logic cn);
        erc_pkg::erc_regs_t t;
        t = s;
        if (ev) begin
            t.wr_ptr  = 3'h0;
            t.rd_ptr  = 3'h0;
            t.count   = 4'h0;
            t.overrun = 1'b0;
        end
        if (cn)
            t.counter = 32'h0000_0000;
        return t;
    endfunction

    // ======================================================================
    // next state
    always_comb begin
        logic [3:0]  set;
        logic [4:0]  k;
        logic        tick;
        logic        setup;
        logic        wr;
        logic        rec;
        logic        pf;
        logic        raw;
        logic [7:0]  a;
        set   = 4'h0;
        nxt_r = r_ff;
        k     = erc_slot(paddr);
        setup = psel && !penable;
        wr    = psel && penable && r_ff.pready && pwrite;
        rec   = (r_ff.st == erc_pkg::ST_RUN);
        pf    = r_ff.sy2[1];
        raw   = r_ff.sy2[3];
        a     = r_ff.nv_addr;
        // pins pass two flops before use
        nxt_r.sy1   = {proc_in, time_code, power_fail, battery_ok};
        nxt_r.sy2   = r_ff.sy1;
        nxt_r.nv_we = 1'b0;

        // millisecond tick and time of day
        tick         = (r_ff.ms_cnt == MS_LAST);
        nxt_r.ms_cnt = tick ? 16'h0000 : r_ff.ms_cnt + 16'h0001;
        if (tick) begin
            nxt_r.ms = (r_ff.ms == `ERC_MS_PER_S) ? 10'h000 : r_ff.ms + 10'h001;
            if (r_ff.ms == `ERC_MS_PER_S)
                nxt_r.sec = (r_ff.sec == `ERC_S_PER_DAY) ? 17'h00000 : r_ff.sec + 17'h00001;
        end

        // minute gap of the time code, then the next pulse edge syncs
        nxt_r.tc_prev = r_ff.sy2[2];
        if (r_ff.sy2[2] && !r_ff.tc_prev) begin
            nxt_r.gap = 11'h000;
            if (r_ff.gap > `ERC_SYNC_GAP_MS) begin
                nxt_r.ms     = 10'h000;
                nxt_r.tvalid = 1'b1;
            end
        end else if (tick && r_ff.gap != 11'h7ff) begin
            nxt_r.gap = r_ff.gap + 11'h001;
        end

        // free-running clock starts from its default
        if (rec && r_ff.ctrl[`ERC_C_FREERUN] && !r_ff.tvalid) begin
            nxt_r.tvalid = 1'b1;
            nxt_r.sec    = 17'h00000;
            nxt_r.ms     = 10'h000;
            nxt_r.date   = `ERC_DATE_RST;
        end

        // input must differ for 1 ms plus debounce before it counts
        if (raw == r_ff.level) begin
            nxt_r.filt = 9'h000;
        end else if (tick) begin
            if (r_ff.filt >= {1'b0, r_ff.param}) begin
                nxt_r.filt  = 9'h000;
                nxt_r.level = raw;
                if (rec) begin
                    if (r_ff.need_tr && r_ff.ctrl[`ERC_C_FULLTIME])
                        nxt_r = erc_push(nxt_r, {1'b1, nxt_r.tvalid, 4'h0, r_ff.date[11:8],
                                                 r_ff.date[4:0], nxt_r.sec});
                    nxt_r.need_tr = 1'b0;
                    nxt_r = erc_push(nxt_r, {1'b0, nxt_r.tvalid, raw, 2'h0, nxt_r.sec, nxt_r.ms});
                    if (raw)
                        nxt_r.counter = r_ff.counter + 32'h0000_0001;
                end
            end else begin
                nxt_r.filt = r_ff.filt + 9'h001;
            end
        end

        // ==================================================================
        // apb slave: answer one cycle after setup
        nxt_r.pready  = setup;
        nxt_r.pslverr = setup && !k[4] && paddr != `ERC_IRQ_STAT && paddr != `ERC_IRQ_MASK;
        if (setup && !pwrite)
            nxt_r.prdata = erc_read(r_ff, paddr);
        if (wr && k[4] && k[3]) begin
            case (k[2:0])
                3'h0: nxt_r.ctrl = pwdata[4:0];
                3'h1: begin
                    if (r_ff.par_ok && pwdata[7:0] != r_ff.param)
                        nxt_r = erc_wipe(nxt_r, 1'b1, 1'b1);
                    nxt_r.param  = pwdata[7:0];
                    nxt_r.par_ok = 1'b1;
                end
                3'h2: begin
                    nxt_r.sec    = pwdata[26:10];
                    nxt_r.ms     = pwdata[9:0];
                    nxt_r.tvalid = 1'b1;
                end
                3'h3: begin
                    // host confirms the head event only while its transfer runs
                    if (r_ff.ctrl[`ERC_C_XFER] && nxt_r.count != 4'h0) begin
                        nxt_r.rd_ptr = nxt_r.rd_ptr + 3'h1;
                        nxt_r.count  = nxt_r.count - 4'h1;
                    end
                end
                default: nxt_r.date = pwdata;
            endcase
        end
        if (wr && paddr == `ERC_IRQ_MASK)
            nxt_r.irq_mask = pwdata[3:0];

        // ==================================================================
        // start, restore and save sequencing
        case (r_ff.st)
            erc_pkg::ST_BOOT: begin
                // marker only exists when the last save ran to its end
                if (nv_rdata == `ERC_NV_MARK) begin
                    nxt_r.st      = erc_pkg::ST_RESTORE;
                    nxt_r.nv_addr = `ERC_NV_PARAM_A;
                end else begin
                    nxt_r.st = erc_pkg::ST_COLD;
                end
            end
            erc_pkg::ST_RESTORE: begin
                case (a)
                    `ERC_NV_PARAM_A: {nxt_r.par_ok, nxt_r.param} = nv_rdata[8:0];
                    `ERC_NV_CTRL_A:  nxt_r.ctrl = nv_rdata[4:0];
                    `ERC_NV_CNT_A:   nxt_r.counter = nv_rdata;
                    `ERC_NV_PTR_A:   {nxt_r.rd_ptr, nxt_r.wr_ptr, nxt_r.count} = nv_rdata[9:0];
                    default:         nxt_r.fifo[3'(a - `ERC_NV_EVT_A)] = nv_rdata;
                endcase
                nxt_r.nv_addr = a + 8'h01;
                if (a == `ERC_NV_LAST_A)
                    nxt_r.st = erc_pkg::ST_REARM;
            end
            erc_pkg::ST_REARM: begin
                // spend the marker so a broken later save ends cold
                nxt_r.nv_we    = 1'b1;
                nxt_r.nv_addr  = `ERC_NV_MARK_A;
                nxt_r.nv_wdata = 32'h0000_0000;
                nxt_r          = erc_wipe(nxt_r, r_ff.ctrl[`ERC_C_EVT_WIPE], r_ff.ctrl[`ERC_C_CNT_WIPE]);
                nxt_r.warm     = 1'b1;
                nxt_r.tvalid   = 1'b0;
                nxt_r.need_tr  = 1'b1;
                set[`ERC_I_WARM] = 1'b1;
                nxt_r.st       = erc_pkg::ST_RUN;
            end
            erc_pkg::ST_COLD: begin
                nxt_r         = erc_wipe(nxt_r, 1'b1, 1'b1);
                nxt_r.fifo    = '0;
                nxt_r.param   = 8'h00;
                nxt_r.par_ok  = 1'b0;
                nxt_r.ctrl    = `ERC_CTRL_RST;
                nxt_r.date    = `ERC_DATE_RST;
                nxt_r.tvalid  = 1'b0;
                nxt_r.warm    = 1'b0;
                nxt_r.need_tr = 1'b1;
                set[`ERC_I_COLD] = 1'b1;
                nxt_r.st      = erc_pkg::ST_WAITPAR;
            end
            erc_pkg::ST_WAITPAR, erc_pkg::ST_RUN: begin
                if (pf) begin
                    nxt_r.st      = r_ff.sy2[0] ? erc_pkg::ST_SAVE : erc_pkg::ST_HALT;
                    nxt_r.nv_addr = `ERC_NV_PARAM_A;
                end else if (r_ff.st == erc_pkg::ST_WAITPAR && nxt_r.par_ok) begin
                    nxt_r.st = erc_pkg::ST_RUN;
                end
            end
            erc_pkg::ST_SAVE: begin
                // strobe, address and data leave together; marker goes last,
                // so a cut save never looks complete
                if (!r_ff.nv_we) begin
                    nxt_r.nv_we    = 1'b1;
                    nxt_r.nv_addr  = a;
                    nxt_r.nv_wdata = erc_nv_word(r_ff, a);
                end else if (a == `ERC_NV_MARK_A) begin
                    nxt_r.st = erc_pkg::ST_HALT;
                end else begin
                    nxt_r.nv_we    = 1'b1;
                    nxt_r.nv_addr  = (a == `ERC_NV_LAST_A) ? `ERC_NV_MARK_A : a + 8'h01;
                    nxt_r.nv_wdata = erc_nv_word(r_ff, nxt_r.nv_addr);
                end
            end
            erc_pkg::ST_HALT: nxt_r.st = erc_pkg::ST_HALT;
            default:          nxt_r.st = erc_pkg::ST_COLD;
        endcase

        // ==================================================================
        // sticky events, write one to clear, set wins
        set[`ERC_I_TVALID] = nxt_r.tvalid && !r_ff.tvalid;
        set[`ERC_I_OVR]    = nxt_r.overrun && !r_ff.overrun;
        if (wr && paddr == `ERC_IRQ_STAT)
            nxt_r.irq_stat = r_ff.irq_stat & ~pwdata[3:0];
        nxt_r.irq_stat = nxt_r.irq_stat | set;
        nxt_r.irq      = |(nxt_r.irq_stat & nxt_r.irq_mask);
    end

    // ======================================================================
    // single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_ff      <= '0;
            r_ff.st   <= erc_pkg::ST_BOOT;
            r_ff.date <= `ERC_DATE_RST;
            r_ff.ctrl <= `ERC_CTRL_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign pready   = r_ff.pready;
    assign prdata   = r_ff.prdata;
    assign pslverr  = r_ff.pslverr;
    assign nv_we    = r_ff.nv_we;
    assign nv_addr  = r_ff.nv_addr;
    assign nv_wdata = r_ff.nv_wdata;
    assign irq      = r_ff.irq;
endmodule // erc_restart_ctrl
`default_nettype wire

//--- erc_map.svh
// register map, field positions and timing constants of the restart controller
// ==========================================================================
`ifndef ERC_MAP_SVH
`define ERC_MAP_SVH
// ==========================================================================
// word image
`define ERC_IN_WORDS    3'h7
`define ERC_OUT_WORDS   3'h5
`define ERC_IN_BASE     8'h00
`define ERC_OUT_BASE    8'h20
`define ERC_IRQ_STAT    8'h40
`define ERC_IRQ_MASK    8'h44
// control word bits
`define ERC_C_CNT_WIPE  0
`define ERC_C_EVT_WIPE  1
`define ERC_C_FULLTIME  2
`define ERC_C_FREERUN   3
`define ERC_C_XFER      4
`define ERC_CTRL_RST    5'h00
// irq bits
`define ERC_I_COLD      0
`define ERC_I_WARM      1
`define ERC_I_TVALID    2
`define ERC_I_OVR       3
// default date {year, month, day}
`define ERC_DATE_RST    32'h07c6_0101
// time base
`define ERC_CLK_HZ      32'd20000000
`define ERC_RESOLVE_MS  32'd1
`define ERC_MS_PER_S    10'h3e7
`define ERC_S_PER_DAY   17'h1517f
`define ERC_SYNC_GAP_MS 11'h5dc
// event buffer and saved image
`define ERC_EVT_DEPTH   4'h8
`define ERC_NV_MARK_A   8'h00
`define ERC_NV_PARAM_A  8'h01
`define ERC_NV_CTRL_A   8'h02
`define ERC_NV_CNT_A    8'h03
`define ERC_NV_PTR_A    8'h04
`define ERC_NV_EVT_A    8'h05
`define ERC_NV_LAST_A   8'h0c
`define ERC_NV_MARK     32'h5a5a_c3c3
`endif

//--- erc_pkg.sv
// types of the restart controller
package erc_pkg;
    // ======================================================================
    // sequencer states, one-hot
    typedef enum logic [7:0] {
        ST_BOOT    = 8'h01,
        ST_RESTORE = 8'h02,
        ST_REARM   = 8'h04,
        ST_COLD    = 8'h08,
        ST_WAITPAR = 8'h10,
        ST_RUN     = 8'h20,
        ST_SAVE    = 8'h40,
        ST_HALT    = 8'h80
    } erc_state_t;

    // ======================================================================
    // whole state of the block
    typedef struct packed {
        erc_state_t       st;
        logic [3:0]       sy1;
        logic [3:0]       sy2;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
        logic [4:0]       ctrl;
        logic [7:0]       param;
        logic             par_ok;
        logic             tvalid;
        logic             warm;
        logic             need_tr;
        logic [15:0]      ms_cnt;
        logic [9:0]       ms;
        logic [16:0]      sec;
        logic [31:0]      date;
        logic [8:0]       filt;
        logic             level;
        logic             tc_prev;
        logic [10:0]      gap;
        logic [31:0]      counter;
        logic [7:0][31:0] fifo;
        logic [2:0]       wr_ptr;
        logic [2:0]       rd_ptr;
        logic [3:0]       count;
        logic             overrun;
        logic [3:0]       irq_stat;
        logic [3:0]       irq_mask;
        logic             irq;
        logic             nv_we;
        logic [7:0]       nv_addr;
        logic [31:0]      nv_wdata;
    } erc_regs_t;
endpackage

//--- erc_restart_ctrl_asserts.sv
// concurrent checks of the restart controller ports
`timescale 1ns/1ps
`default_nettype none
`include "erc_map.svh"

module erc_restart_ctrl_asserts #(
    parameter int unsigned MS_CYCLES = 20000
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        proc_in,
    input wire logic        time_code,
    input wire logic        power_fail,
    input wire logic        battery_ok,
    input wire logic [31:0] nv_rdata,
    input wire logic        nv_we,
    input wire logic [7:0]  nv_addr,
    input wire logic [31:0] nv_wdata,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ======================================================================
    // a write to status or mask is the only thing that may drop irq
    logic irq_wr;
    assign irq_wr = psel && penable && pwrite && paddr[7:3] == 5'h08;

    // ======================================================================
    // bus answers
    chk_ready_zero: assert property (psel && !penable |=> pready)
        else $error("pready missing in access cycle");
    chk_ready_one: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_hole: assert property (pready && paddr >= 8'h48 |-> pslverr)
        else $error("unmapped word not refused");
    chk_err_image: assert property (pready && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("input word refused");

    // ======================================================================
    // save burst: thirteen strobes in a row, marker written last
    chk_save_burst: assert property (nv_we && nv_addr == 8'h01 |-> nv_we[*8] ##1 nv_we[*5])
        else $error("save burst broken");
    chk_save_step: assert property (nv_we && nv_addr > 8'h00 && nv_addr < 8'h0c
        |=> nv_we && nv_addr == $past(nv_addr) + 8'h01)
        else $error("save address not stepping");
    chk_save_mark: assert property (nv_we && nv_addr == 8'h0c |=> nv_we && nv_addr == 8'h00 && nv_wdata == `ERC_NV_MARK)
        else $error("marker not written after image");
    chk_mark_last: assert property (nv_we && nv_addr == 8'h00 && nv_wdata == `ERC_NV_MARK |-> $past(nv_addr) == 8'h0c)
        else $error("marker touched before image complete");
    chk_irq_drop: assert property ($fell(irq) |-> $past(irq_wr) || $past(irq_wr, 2))
        else $error("irq fell without software clear");

    // ======================================================================
    // main scenarios seen
    cov_save: cover property (nv_we && nv_addr == 8'h0c);
    cov_err: cover property (pready && pslverr);
    cov_irq: cover property ($rose(irq));
endmodule // erc_restart_ctrl_asserts

bind erc_restart_ctrl erc_restart_ctrl_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .proc_in, .time_code, .power_fail, .battery_ok, .nv_rdata, .nv_we, .nv_addr, .nv_wdata, .irq
);
`default_nettype wire

//--- erc_nv_ram.sv
// battery-backed word store facing the restart controller
`timescale 1ns/1ps
`default_nettype none

module erc_nv_ram (
    input  wire logic        pclk,
    input  wire logic        nv_we,
    input  wire logic [7:0]  nv_addr,
    input  wire logic [31:0] nv_wdata,
    output logic      [31:0] nv_rdata
);
    // ======================================================================
    // blank at power-up so the first start is cold; no reset, contents survive
    logic [31:0] mem [0:12];
    initial for (int i = 0; i < 13; i++) mem[i] = 32'h0000_0000;
    always @(posedge pclk) if (nv_we && nv_addr < 8'h0d) mem[nv_addr] <= nv_wdata;
    // combinational read; holes give a moving pattern, never a stale word
    assign nv_rdata = (nv_addr < 8'h0d) ? mem[nv_addr] : {4{~nv_addr}};
endmodule // erc_nv_ram
`default_nettype wire

//--- event_recorder_restart_control_tb.sv
// self-checking bench of the restart controller
`timescale 1ns/1ps
`default_nettype none

module event_recorder_restart_control_tb;
    localparam int unsigned MS = 2;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic        proc_in, time_code, power_fail, battery_ok, nv_we;
    logic [7:0]  paddr, nv_addr;
    logic [31:0] pwdata, prdata, nv_rdata, nv_wdata, tv;
    logic [32:0] q_exp[$], q_msk[$];
    int          error_cnt, tests_run, cyc, seed;

    erc_restart_ctrl #(.MS_CYCLES(MS)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .proc_in, .time_code, .power_fail, .battery_ok,
        .nv_rdata, .nv_we, .nv_addr, .nv_wdata, .irq);
    erc_nv_ram u_nv (.pclk, .nv_we, .nv_addr, .nv_wdata, .nv_rdata);

    // ======================================================================
    // clock and hang guard; the run needs a few thousand cycles
    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic summarize();
        if (error_cnt == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic bad(input logic [32:0] g, input logic [32:0] e);
        error_cnt++;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    endtask
    task automatic pin(input logic g, input logic e);
        tests_run++;
        if (g !== e) bad({32'h0, g}, {32'h0, e});
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // ======================================================================
    // apb master: request held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    // notes the expectation, error bit included, before the read starts
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
        q_exp.push_back({a >= 8'h48, e});
        q_msk.push_back({1'b1, m});
        xfer(1'b0, a, 32'h0);
    endtask
    task automatic set_in(input logic v);
        proc_in <= v;
        wait_clk(100);
    endtask
    // supply drop, then restart; halt state seen while the drop lasts
    task automatic pwr_loss(input logic bat);
        battery_ok <= bat;
        power_fail <= 1'b1;
        wait_clk(40);
        rd(8'h00, 32'h8000_0000, 32'hff00_0000);
        power_fail <= 1'b0;
        presetn    <= 1'b0;
        wait_clk(2);
        presetn    <= 1'b1;
        wait_clk(20);
    endtask

    // ======================================================================
    // result watcher: oldest note against each completed read
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            tests_run++;
            if ((({pslverr, prdata} ^ q_exp[0]) & q_msk[0]) !== 33'h0) bad({pslverr, prdata}, q_exp[0]);
            void'(q_exp.pop_front());
            void'(q_msk.pop_front());
        end
    end

    // ======================================================================
    // main sequence
    initial begin
        seed = 26;
        error_cnt = 0;
        tests_run = 0;
        cyc = 0;
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {proc_in, time_code, power_fail, battery_ok} = 4'h0;
        wait_clk(2);
        presetn <= 1'b1;
        wait_clk(5);
        rd(8'h00, 32'h1000_0000, 32'hff00_000f);
        rd(8'h08, 32'h0);
        rd(8'h14, 32'h0);
        rd(8'h18, 32'h0);
        rd(8'h40, 32'h1, 32'hf);
        wr(8'h44, 32'h1);
        wait_clk(3);
        pin(irq, 1'b1);
        wr(8'h40, 32'h1);
        wait_clk(3);
        pin(irq, 1'b0);
        set_in(1'b1);
        rd(8'h14, 32'h0);
        rd(8'h08, 32'h0);
        set_in(1'b0);
        // free-run clock, full time report, host transfer active
        wr(8'h20, 32'h1c);
        wr(8'h24, 32'h1);
        wait_clk(4);
        rd(8'h00, 32'h2000_0005, 32'hff00_000f);
        rd(8'h10, 32'h07c6_0101);
        rd(8'h0c, 32'h0, 32'h07ff_fc00);
        set_in(1'b1);
        rd(8'h14, 32'h2);
        rd(8'h04, 32'h8000_0000, 32'h8000_0000);
        rd(8'h08, 32'h1);
        wr(8'h2c, $random(seed));
        rd(8'h14, 32'h1);
        rd(8'h04, 32'h6000_0000, 32'he000_0000);
        wr(8'h18, 32'h9);
        rd(8'h18, 32'h1);
        rd(8'h48, 32'h0);
        wr(8'h24, 32'h2);
        rd(8'h14, 32'h0);
        rd(8'h08, 32'h0);
        set_in(1'b0);
        set_in(1'b1);
        set_in(1'b0);
        pwr_loss(1'b1);
        rd(8'h00, 32'h2000_0006, 32'hff00_0006);
        rd(8'h18, 32'h2);
        rd(8'h08, 32'h1);
        rd(8'h14, 32'h3);
        rd(8'h40, 32'h2, 32'h3);
        wr(8'h20, 32'h1f);
        pwr_loss(1'b1);
        rd(8'h14, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h18, 32'h2);
        pwr_loss(1'b0);
        rd(8'h00, 32'h1000_0000, 32'hff00_000f);
        wr(8'h24, 32'h1);
        wait_clk(3);
        rd(8'h00, 32'h2000_0004, 32'hff00_000f);
        // minute gap of the receiver, then one pulse syncs the clock
        wait_clk(3100);
        time_code <= 1'b1;
        wait_clk(5);
        time_code <= 1'b0;
        rd(8'h00, 32'h2000_0005, 32'hff00_000f);
        tv = 32'h1400 | ($unsigned($random(seed)) % 32'd900);
        wr(8'h28, tv);
        rd(8'h00, 32'h2000_0005, 32'hff00_000f);
        rd(8'h0c, 32'h1400, 32'h07ff_fc00);
        rd(8'h40, 32'h5, 32'h5);
        summarize();
    end
endmodule // event_recorder_restart_control_tb
`default_nettype wire
